//--- verilog/sine_slice_defs.vh
// Offsets, field positions, reset values and timing counts of the slice
// decoder. Assumes inclusion by bare name from the design files.
`ifndef SINE_SLICE_DEFS_VH
`define SINE_SLICE_DEFS_VH
`define CLK_HZ           25000000
`define FREQ_STEP_DHZ    39
`define PHASE_BITS       16
`define TICK_DIV         ((`CLK_HZ * 10) / (`FREQ_STEP_DHZ * (1 << `PHASE_BITS)))
`define ADDR_W           3
`define OFS_WORD0        3'h0
`define OFS_WORD1        3'h1
`define OFS_WORD2        3'h2
`define OFS_WORD3        3'h3
`define OFS_CTRL         3'h4
`define OFS_STATUS       3'h5
`define OFS_HALFCNT      3'h6
`define AMP_MSB          11
`define CYC_MSB          15
`define CYC_LSB          8
`define FREQ_MSB         7
`define FREQ_LSB         0
`define CONTINUOUS_REPEAT_ENABLE_BIT         12
`define MODE_MSB         11
`define MODE_LSB         10
`define HALF_CYCLE_EXTRA_BIT         9
`define PHASE_INVERT_SELECT_BIT         8
`define SHUP_MSB         7
`define SHUP_LSB         4
`define SHDN_MSB         3
`define SHDN_LSB         0
`define CTRL_START_BIT   0
`define CTRL_STOP_BIT    1
`define CTRL_NEXT_BIT    2
`define SRC_MSB          5
`define SRC_LSB          4
`define SRC_RAM_SYNTH    2'h3
`define MODE_UNI_POS     2'h1
`define WORD_RESET       16'h0000
`define SRC_RESET        2'h0
`endif

//--- verilog/sine_phase_gen.v
// Phase accumulator that steps a sine period in 3.9 Hz units.
// Assumes a run level held by the decoder for the whole slice, on the same clock.
`include "sine_slice_defs.vh"
module sine_phase_gen #(
  parameter TICK_DIV = `TICK_DIV,
  parameter PW       = `PHASE_BITS
) (
  input  wire          clk_i,
  input  wire          reset_i,
  input  wire          run_i,
  input  wire [7:0]    freq_i,
  output reg  [PW-1:0] phase_o,
  output reg           half_o,
  output reg           period_o
);
  reg  [7:0]  div_reg;
  wire        tick;
  wire [PW:0] sum;

  // Slow step rate is a one-cycle enable from this divider.
  assign tick = (div_reg == TICK_DIV[7:0] - 8'h01);
  assign sum  = {1'b0, phase_o} + {{(PW-7){1'b0}}, freq_i};

  always @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      div_reg  <= 8'h00;
      phase_o  <= {PW{1'b0}};
      half_o   <= 1'b0;
      period_o <= 1'b0;
    end else begin
      div_reg  <= tick ? 8'h00 : div_reg + 8'h01;
      half_o   <= 1'b0;
      period_o <= 1'b0;
      if (tick) begin
        phase_o  <= sum[PW-1:0];
        half_o   <= sum[PW] | (sum[PW-1] & ~phase_o[PW-1]);
        period_o <= sum[PW];
      end
    end
  end
endmodule

//--- verilog/sine_slice_parameter_decode.v
// Slice parameter decoder and play sequencer of the sine synthesizer.
// Assumes a same-clock register master with one-cycle strobes.
//
// The plain strobed port and the register addresses were decided locally.
`include "sine_slice_defs.vh"
module sine_slice_parameter_decode #(
  parameter TICK_DIV = `TICK_DIV
) (
  input  wire                 clk_i,
  input  wire                 reset_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [15:0]          wdata_i,
  input  wire                 write_i,
  input  wire                 read_i,
  output reg  [15:0]          rdata_o,
  output reg  [11:0]          amplitude_o,
  output reg                  amplitude_valid_o,
  output wire [15:0]          phase_o,
  output reg  [1:0]           play_state_o,
  output reg  [1:0]           slice_polarity_mode_o,
  output reg                  phase_invert_select_o,
  output reg  [3:0]           ramp_up_shape_o,
  output reg  [3:0]           ramp_down_shape_o,
  output reg                  slice_done_o,
  output reg                  slice_advance_o
);
  localparam S_IDLE = 2'h0;
  localparam S_UP   = 2'h1;
  localparam S_PLAY = 2'h2;
  localparam S_DOWN = 2'h3;

  reg  [15:0] slice_mem [0:3];
  reg  [1:0]  playback_source_select_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [8:0]  half_cnt_reg;
  reg  [8:0]  half_cnt_next;
  reg         stop_pend_reg;
  reg         next_pend_reg;
  reg         done_next;
  reg         adv_next;
  wire        half_tick;
  wire        period_tick;
  wire [15:0] phase_raw;
  wire [7:0]  cycles_fld;
  wire [7:0]  frequency_fld;
  wire        half_cycle_extra;
  wire        continuous_repeat_enable;
  wire [3:0]  shape_up;
  wire [3:0]  shape_dn;
  wire [8:0]  total_cycle_count;
  wire        start_req;
  wire        stop_req;
  wire        next_slice_request;
  wire        ctrl_wr;

  // Read mux of the register map.
  function [15:0] read_word;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFS_WORD0:   read_word = slice_mem[0];
        `OFS_WORD1:   read_word = slice_mem[1];
        `OFS_WORD2:   read_word = slice_mem[2];
        `OFS_WORD3:   read_word = slice_mem[3];
        `OFS_CTRL:    read_word = {10'h000, playback_source_select_reg,
                                   4'h0};
        `OFS_STATUS:  read_word = {12'h000, next_pend_reg, stop_pend_reg,
                                   state_reg};
        `OFS_HALFCNT: read_word = {7'h00, half_cnt_reg};
        default:      read_word = 16'h0000;
      endcase
    end
  endfunction

  // State after play: ramp-down only when a ramp-down shape is chosen.
  function [1:0] end_state;
    input [3:0] shape;
    begin
      end_state = (shape != 4'h0) ? S_DOWN : S_IDLE;
    end
  endfunction

  // A command bit counts only on a write to the control index.
  function ctrl_cmd;
    input               wr;
    input [`ADDR_W-1:0] a;
    input [15:0]        v;
    input integer       b;
    begin
      ctrl_cmd = wr && (a == `OFS_CTRL) && v[b];
    end
  endfunction

  // Slice field decode.
  assign cycles_fld               = slice_mem[2][`CYC_MSB:`CYC_LSB];
  assign frequency_fld            = slice_mem[2][`FREQ_MSB:`FREQ_LSB];
  assign half_cycle_extra         = slice_mem[3][`HALF_CYCLE_EXTRA_BIT];
  assign continuous_repeat_enable = slice_mem[3][`CONTINUOUS_REPEAT_ENABLE_BIT];
  assign shape_up                 = slice_mem[3][`SHUP_MSB:`SHUP_LSB];
  assign shape_dn                 = slice_mem[3][`SHDN_MSB:`SHDN_LSB];
  // Count in half periods: cycles doubled plus the half-cycle bit.
  assign total_cycle_count  = {cycles_fld, half_cycle_extra};
  assign ctrl_wr            = write_i && (addr_i == `OFS_CTRL);
  assign start_req          = ctrl_cmd(write_i, addr_i, wdata_i,
                                       `CTRL_START_BIT);
  assign stop_req           = ctrl_cmd(write_i, addr_i, wdata_i,
                                       `CTRL_STOP_BIT);
  assign next_slice_request = ctrl_cmd(write_i, addr_i, wdata_i,
                                       `CTRL_NEXT_BIT);
  assign phase_o            = phase_raw;

  // The phase restarts from zero at every slice start.
  sine_phase_gen #(
    .TICK_DIV (TICK_DIV),
    .PW       (16)
  ) u_phase (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .run_i    (state_reg != S_IDLE),
    .freq_i   (frequency_fld),
    .phase_o  (phase_raw),
    .half_o   (half_tick),
    .period_o (period_tick)
  );

  // Register writes and read data one cycle after the strobe.
  always @(posedge clk_i) begin
    if (reset_i) begin
      slice_mem[0]               <= `WORD_RESET;
      slice_mem[1]               <= `WORD_RESET;
      slice_mem[2]               <= `WORD_RESET;
      slice_mem[3]               <= `WORD_RESET;
      playback_source_select_reg <= `SRC_RESET;
      rdata_o                    <= 16'h0000;
    end else begin
      if (write_i && !addr_i[2]) begin
        slice_mem[addr_i[1:0]] <= wdata_i;
      end
      if (ctrl_wr) begin
        playback_source_select_reg <= wdata_i[`SRC_MSB:`SRC_LSB];
      end
      rdata_o <= read_i ? read_word(addr_i) : 16'h0000;
    end
  end

  // Play sequencer.
  always @* begin
    state_next    = state_reg;
    half_cnt_next = half_cnt_reg;
    done_next     = 1'b0;
    adv_next      = 1'b0;
    case (state_reg)
      S_IDLE: begin
        half_cnt_next = 9'h000;
        if (start_req) begin
          state_next = (shape_up != 4'h0) ? S_UP : S_PLAY;
        end
      end
      S_UP: begin
        if (period_tick) begin
          state_next = S_PLAY;
        end
      end
      S_PLAY: begin
        // Play ends at a period edge on a stop, or at a half-period edge when the count runs out.
        if (continuous_repeat_enable) begin
          // Cycle count is not consulted here.
          if (period_tick && stop_pend_reg) begin
            state_next = end_state(shape_dn);
          end
        end else if (half_tick) begin
          half_cnt_next = half_cnt_reg + 9'h001;
          if (half_cnt_next >= total_cycle_count) begin
            state_next = end_state(shape_dn);
          end else if (period_tick && stop_pend_reg) begin
            state_next = end_state(shape_dn);
          end
        end
        if (continuous_repeat_enable && period_tick && stop_pend_reg) begin
          done_next = (shape_dn == 4'h0);
          adv_next  = (shape_dn == 4'h0) && next_pend_reg;
        end else if (!continuous_repeat_enable && state_next == S_IDLE) begin
          done_next = 1'b1;
          adv_next  = next_pend_reg;
        end
      end
      S_DOWN: begin
        if (period_tick) begin
          state_next = S_IDLE;
          done_next  = 1'b1;
          adv_next   = next_pend_reg;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      state_reg       <= S_IDLE;
      half_cnt_reg    <= 9'h000;
      stop_pend_reg   <= 1'b0;
      next_pend_reg   <= 1'b0;
      slice_done_o    <= 1'b0;
      slice_advance_o <= 1'b0;
    end else begin
      state_reg       <= state_next;
      half_cnt_reg    <= half_cnt_next;
      slice_done_o    <= done_next;
      slice_advance_o <= adv_next;
      // A request arriving in the cycle that leaves for idle is kept; one arriving in idle is not.
      // Any request left over is dropped in idle, so a new start
      // is never cut short by a command meant for the last slice.
      if ((stop_req || next_slice_request) && state_reg != S_IDLE) begin
        stop_pend_reg <= 1'b1;
      end else if (state_reg == S_IDLE || state_next == S_IDLE) begin
        stop_pend_reg <= 1'b0;
      end
      if (next_slice_request && state_reg != S_IDLE) begin
        next_pend_reg <= 1'b1;
      end else if (state_reg == S_IDLE || state_next == S_IDLE) begin
        next_pend_reg <= 1'b0;
      end
    end
  end

  // Decoded drive settings.
  always @(posedge clk_i) begin
    if (reset_i) begin
      amplitude_o           <= 12'h000;
      amplitude_valid_o     <= 1'b0;
      play_state_o          <= S_IDLE;
      slice_polarity_mode_o <= 2'h0;
      phase_invert_select_o <= 1'b0;
      ramp_up_shape_o       <= 4'h0;
      ramp_down_shape_o     <= 4'h0;
    end else begin
      if (playback_source_select_reg == `SRC_RAM_SYNTH) begin
        amplitude_o       <= slice_mem[1][`AMP_MSB:0];
        amplitude_valid_o <= 1'b1;
      end else begin
        amplitude_o       <= 12'h000;
        amplitude_valid_o <= 1'b0;
      end
      play_state_o          <= state_next;
      slice_polarity_mode_o <= slice_mem[3][`MODE_MSB:`MODE_LSB];
      phase_invert_select_o <= slice_mem[3][`PHASE_INVERT_SELECT_BIT];
      ramp_up_shape_o       <= shape_up;
      ramp_down_shape_o     <= shape_dn;
    end
  end
endmodule

//--- testbench/sine_slice_checker.sv
// Concurrent checks on the slice decoder ports.
// Assumes one clock domain and a synchronous active high reset.
module sine_slice_checker (
  input logic        clk_i,
  input logic        reset_i,
  input logic [2:0]  addr_i,
  input logic [15:0] wdata_i,
  input logic        write_i,
  input logic        read_i,
  input logic [15:0] rdata_o,
  input logic [11:0] amplitude_o,
  input logic        amplitude_valid_o,
  input logic [15:0] phase_o,
  input logic [1:0]  play_state_o,
  input logic        slice_done_o,
  input logic        slice_advance_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] freq_reg;
  logic       continuous_repeat_enable_reg;
  logic       pend_reg;
  wire        ctl_w = write_i && addr_i == 3'h4;
  // Shadows of frequency, continuous bit and a pending end request.
  always @(posedge clk_i) begin
    if (reset_i) begin
      freq_reg <= 8'h00;
      continuous_repeat_enable_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      if (write_i && addr_i == 3'h2) freq_reg <= wdata_i[7:0];
      if (write_i && addr_i == 3'h3) continuous_repeat_enable_reg <= wdata_i[12];
      if (ctl_w && wdata_i[2:1] != 2'h0) pend_reg <= 1'b1;
      else if (play_state_o == 2'h0) pend_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rd_idle; !$past(read_i) |-> rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data leaked");
  property p_rd_gap; read_i && addr_i == 3'h7 |=> rdata_o == 16'h0000;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not 0");
  property p_amp_off; !amplitude_valid_o |-> amplitude_o == 12'h000;
  endproperty
  a_amp_off: assert property (p_amp_off) else $error("amplitude leaked");
  property p_amp_on; ctl_w && wdata_i[5:4] == 2'h3 |-> ##2 amplitude_valid_o;
  endproperty
  a_amp_on: assert property (p_amp_on) else $error("amplitude not valid");
  property p_amp_no; ctl_w && wdata_i[5:4] != 2'h3 |-> ##2 !amplitude_valid_o;
  endproperty
  a_amp_no: assert property (p_amp_no) else $error("amplitude valid");
  property p_step;
    play_state_o != 2'h0 && $past(play_state_o) != 2'h0 &&
    phase_o != $past(phase_o) |-> phase_o == $past(phase_o) + {8'h00, freq_reg};
  endproperty
  a_step: assert property (p_step) else $error("bad phase step");
  property p_continuous_repeat_enable;
    continuous_repeat_enable_reg && !pend_reg && !ctl_w && play_state_o == 2'h2 |=>
    play_state_o == 2'h2;
  endproperty
  a_continuous_repeat_enable: assert property (p_continuous_repeat_enable) else $error("left repeat");
  property p_adv; slice_advance_o |-> slice_done_o; endproperty
  a_adv: assert property (p_adv) else $error("lone advance");
  property p_done; slice_done_o |=> !slice_done_o && play_state_o == 2'h0;
  endproperty
  a_done: assert property (p_done) else $error("bad done pulse");
  c_adv: cover property (slice_done_o && slice_advance_o);
  c_end: cover property (slice_done_o && !slice_advance_o);
  c_rep: cover property (continuous_repeat_enable_reg && pend_reg && play_state_o == 2'h2);
endmodule
bind sine_slice_parameter_decode sine_slice_checker u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
  .amplitude_o(amplitude_o), .amplitude_valid_o(amplitude_valid_o),
  .phase_o(phase_o), .play_state_o(play_state_o),
  .slice_done_o(slice_done_o), .slice_advance_o(slice_advance_o));

//--- testbench/sine_slice_parameter_decode_tb.sv
// Self-checking bench for the slice decoder with random slices.
// Assumes the decoder is built with a one-cycle phase tick.
module sine_slice_parameter_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0;
  logic        reset_i = 1;
  logic [2:0]  addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        write_i = 0;
  logic        read_i = 0;
  wire  [15:0] rdata, phase;
  wire  [11:0] amp;
  wire  [1:0]  state, pol;
  wire  [3:0]  up, dn;
  wire         amp_v, inv, done, adv;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          cnt[4];
  logic [31:0] seed = 32'h8C44;
  logic [15:0] d, w2, w3;
  logic        adv_seen, h;
  always #20 clk_i = ~clk_i;
  sine_slice_parameter_decode #(.TICK_DIV(1)) dut (.clk_i(clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i),
    .read_i(read_i), .rdata_o(rdata), .amplitude_o(amp),
    .amplitude_valid_o(amp_v), .phase_o(phase), .play_state_o(state),
    .slice_polarity_mode_o(pol), .phase_invert_select_o(inv),
    .ramp_up_shape_o(up), .ramp_down_shape_o(dn), .slice_done_o(done),
    .slice_advance_o(adv));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic bit near(input int a, input int b);
    near = (a - b) <= 3 && (b - a) <= 3;
  endfunction
  task check(input string n, input [31:0] s, input [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %0h got %0h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input [2:0] a, input [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task rd(input [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 d = rdata;
  endtask
  // Plays one slice and counts cycles in each state; cmd goes when the play-state count reaches at.
  task play(input [2:0] cmd, input int at);
    cnt = '{0, 0, 0, 0};
    adv_seen = 1'b0;
    wr(3'h2, w2);
    wr(3'h3, w3);
    wr(3'h4, 16'h0031);
    wdata_i <= {12'h003, 1'b0, cmd};
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk_i);
      write_i <= (cnt[2] == at);
      #1;
      cnt[state]++;
      if (done === 1'b1) begin
        adv_seen = adv;
        break;
      end
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 check("state", state, 0);
    check("ampv", amp_v, 0);
    wr(3'h2, 16'h0310);
    rd(3'h2);
    check("word2", d, 16'h0310);
    wr(3'h7, 16'hFFFF);
    rd(3'h7);
    check("unmapped", d, 0);
    seed = lfsr(seed);
    wr(3'h3, seed[15:0]);
    @(posedge clk_i);
    #1 check("fields", {pol, inv, up, dn}, {seed[11:10], seed[8:0]});
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      wr(3'h1, seed[15:0]);
      wr(3'h4, 16'(s << 4));
      repeat (2) @(posedge clk_i);
      #1 check("amp", amp, s == 3 ? seed[11:0] : 0);
      check("ampv", amp_v, s == 3);
    end
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      w2 = {6'h00, k == 0 ? 2'h0 : seed[1:0], seed[15:8] | 8'h40};
      h = (w2[15:8] == 8'h00) | seed[2];
      w3 = {3'h0, 1'b0, 2'h1, h, 9'h000};
      play(3'h0, -1);
      check("len", near(cnt[2], (2 * int'(w2[15:8]) + h) * 32768 /
        int'(w2[7:0])), 1);
      check("adv", adv_seen, 0);
    end
    w2 = 16'h0180;
    w3 = 16'h0411;
    play(3'h0, -1);
    check("ramps", {near(cnt[1], 512), near(cnt[2], 512),
      near(cnt[3], 512)}, 3'h7);
    @(posedge clk_i);
    #1 check("phase", phase, 0);
    w3 = 16'h1400;
    for (int c = 2; c <= 4; c += 2) begin
      play(3'(c), 1700);
      check("continuous_repeat_enable", near(cnt[2], 2048), 1);
      check("next", adv_seen, c == 4);
    end
    rd(3'h5);
    check("status", d, 0);
    rd(3'h4);
    check("ctrl", d, 16'h0030);
    stop_test;
  end
endmodule
